// ==== inc/cbc_pkg.sv ====
package cbc_pkg;
	localparam int          APB_AW        = 8;
	localparam int          APB_DW        = 32;
	localparam logic [7:0]  REG_CMD       = 8'h00;
	localparam logic [7:0]  REG_ADDR      = 8'h04;
	localparam logic [7:0]  REG_WDATA     = 8'h08;
	localparam logic [7:0]  REG_RDATA     = 8'h0c;
	localparam logic [7:0]  REG_STATUS    = 8'h10;
	localparam logic [7:0]  REG_CFG       = 8'h14;
	localparam logic [7:0]  REG_PROG      = 8'h18;
	localparam logic [7:0]  REG_VPAGE     = 8'h1c;
	localparam logic [7:0]  REG_RFCNT     = 8'h20;
	localparam logic [2:0]  CMD_FETCH     = 3'h0;
	localparam logic [2:0]  CMD_MEMRD     = 3'h1;
	localparam logic [2:0]  CMD_MEMWR     = 3'h2;
	localparam logic [2:0]  CMD_IORD      = 3'h3;
	localparam logic [2:0]  CMD_IOWR      = 3'h4;
	localparam logic [2:0]  CMD_HALT      = 3'h5;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_PEND       = 1;
	localparam int          ST_HALTED     = 2;
	localparam int          ST_HOLDACK    = 3;
	localparam int          ST_IRQ_EN     = 4;
	localparam int          ST_IM_LSB     = 5;
	localparam int          ST_NMIPEND    = 7;
	localparam int          ST_FLOAT      = 8;
	localparam int          ST_W          = 9;
	localparam int          CFG_IRQ_EN    = 0;
	localparam int          CFG_IM_LSB    = 1;
	localparam logic [15:0] PROG_RESET    = 16'h0000;
	localparam logic [15:0] NMI_VEC       = 16'h0066;
	localparam logic [15:0] RST_VEC       = 16'h0038;
	localparam logic [1:0]  IM_RESET      = 2'h0;
	localparam logic [1:0]  IM_VECTORED   = 2'h2;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [6:0]  RF_STEP       = 7'h01;
	localparam logic [1:0]  AUTO_WAIT_IO  = 2'h1;
	localparam logic [1:0]  AUTO_WAIT_ACK = 2'h2;
	localparam logic [1:0]  AUTO_WAIT_NONE = 2'h0;
	localparam int          RESET_MIN_CLK = 3;

	typedef enum logic [2:0] {TS_IDLE, TS_T1, TS_T2, TS_TW, TS_T3, TS_T4} cbc_tst_type;
	typedef enum logic [2:0] {K_FETCH, K_MEMRD, K_MEMWR, K_IORD, K_IOWR, K_INTACK} cbc_kind_type;
	typedef enum logic [1:0] {OP_CMD, OP_NMI, OP_INT, OP_NOP} cbc_op_type;
endpackage

// ==== inc/cbc_cyc_if.sv ====
interface cbc_cyc_if;
	import cbc_pkg::*;
	logic         start;
	cbc_kind_type kind;
	logic         wait_n;
	cbc_tst_type  tst;
	logic         ph;
	cbc_kind_type kind_now;
	logic         xfer;
	logic         last;
	logic         busy;
	modport ctl (output start, kind, wait_n, input tst, ph, kind_now, xfer, last, busy);
	modport seq (input start, kind, wait_n, output tst, ph, kind_now, xfer, last, busy);
endinterface

// ==== verilog/cbc_tseq.sv ====
module cbc_tseq (
	input wire logic pclk,
	input wire logic presetn,
	cbc_cyc_if.seq   cyc
);
	import cbc_pkg::*;

	cbc_tst_type  tst_r;
	logic         ph_r;
	cbc_kind_type kind_r;
	logic [1:0]   wcnt_r;
	logic         wait_smp_r;
	logic         four_t;
	logic         stretch;
	logic [1:0]   auto_w;

	assign four_t = (kind_r == K_FETCH) || (kind_r == K_INTACK);
	assign stretch = (wcnt_r != AUTO_WAIT_NONE) || !wait_smp_r;
	assign auto_w = (kind_r == K_IORD || kind_r == K_IOWR) ? AUTO_WAIT_IO :
		(kind_r == K_INTACK) ? AUTO_WAIT_ACK : AUTO_WAIT_NONE;

	assign cyc.tst = tst_r;
	assign cyc.ph = ph_r;
	assign cyc.kind_now = kind_r;
	assign cyc.busy = tst_r != TS_IDLE;
	assign cyc.xfer = ph_r && (tst_r == TS_T2 || tst_r == TS_TW) && !stretch;
	assign cyc.last = ph_r && (tst_r == TS_T4 || (tst_r == TS_T3 && !four_t));

	// each T state is a high half (ph 0) and a low half (ph 1)
	// wait taken at the falling-edge point of T2 and of each wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_smp_r <= 1'b1;
		else if (!ph_r && (tst_r == TS_T2 || tst_r == TS_TW))
			wait_smp_r <= cyc.wait_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tst_r <= TS_IDLE;
			ph_r <= 1'b0;
			kind_r <= K_FETCH;
			wcnt_r <= AUTO_WAIT_NONE;
		end else if (tst_r == TS_IDLE || cyc.last) begin
			ph_r <= 1'b0;
			if (cyc.start) begin
				tst_r <= TS_T1;
				kind_r <= cyc.kind;
			end else begin
				tst_r <= TS_IDLE;
			end
		end else begin
			ph_r <= !ph_r;
			if (ph_r) begin
				unique case (tst_r)
					TS_T1: begin
						tst_r <= TS_T2;
						wcnt_r <= auto_w;
					end
					TS_T2, TS_TW: begin
						if (stretch) begin
							tst_r <= TS_TW;
							if (wcnt_r != AUTO_WAIT_NONE)
								wcnt_r <= wcnt_r - 2'h1;
						end else begin
							tst_r <= TS_T3;
						end
					end
					TS_T3: tst_r <= TS_T4;
					TS_T4, TS_IDLE: tst_r <= tst_r;
				endcase
			end
		end
	end
endmodule

// ==== verilog/cbc_top.sv ====
// Summary of operation
// - drive 16-bit floatable address bus
// - 8-bit two-way floatable data bus
// - honour hold at cycle end, float bus
// - acknowledge hold only after lines float
// - halt: indicator on, run refresh NOPs
// - maskable request at instruction end, if enabled
// - io request with valid port address in I/O cycles, with program counter on the bus in acknowledge
// - interrupt acknowledge: io request with fetch marker
// - fetch marker with memory request on fetch
// - falling-edge NMI, outranks, restarts at 0066
// - reset clears state, floats bus, mode 0
// - refresh strobe: low seven bits refresh address
// - wait states while wait input low
// - write strobe only with stable data
// - machine cycle three or more T states
// - fetch: address, then request and read together
// - wait sampled at falling point of T2
// - refresh in T3 and T4 of fetch
// - memory cycles: request once address stable
// - one automatic wait in I/O cycles
// - two automatic waits in interrupt acknowledge
module cbc_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cbc_pkg::APB_AW-1:0]  paddr,
	input  wire logic [cbc_pkg::APB_DW-1:0]  pwdata,
	output logic      [cbc_pkg::APB_DW-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [15:0]                 addr_o,
	output logic                             addr_oe,
	input  wire logic [7:0]                  data_i,
	output logic      [7:0]                  data_o,
	output logic                             data_oe,
	output logic                             ctl_oe,
	output logic                             memory_request_n,
	output logic                             io_request_n,
	output logic                             read_strobe_n,
	output logic                             write_strobe_n,
	output logic                             opcode_fetch_marker_n,
	output logic                             refresh_strobe_n,
	output logic                             halted_indicator_n,
	output logic                             bus_hold_ack_n,
	input  wire logic                        wait_request_n,
	input  wire logic                        bus_hold_request_n,
	input  wire logic                        irq_request_n,
	input  wire logic                        nmi_n
);
	import cbc_pkg::*;

	cbc_cyc_if cyc ();

	cbc_tseq u_tseq (
		.pclk    (pclk),
		.presetn (presetn),
		.cyc     (cyc)
	);

	logic         cmd_pend_r;
	logic [2:0]   cmd_code_r;
	logic [2:0]   cur_code_r;
	logic [15:0]  cmd_addr_r;
	logic [7:0]   wdata_r;
	logic [7:0]   rdata_r;
	logic [15:0]  program_counter_r;
	logic         irq_enable_latch_r;
	logic [1:0]   im_r;
	logic [7:0]   vector_page_r;
	logic [7:0]   refresh_counter_r;
	logic         halted_r;
	logic         nmi_q_r;
	logic         nmi_pend_r;
	logic         float_r;
	logic         ack_r;
	logic         boundary_r;
	cbc_op_type   op_r;
	cbc_op_type   op_nxt;
	logic         start_nxt;
	cbc_kind_type kind_nxt;
	logic         slot;
	logic         done;
	logic         acc;
	logic         wr_en;
	logic         hit;
	logic         nmi_fall;
	logic [ST_W-1:0] stat;
	logic         mem_rq;
	logic         io_rq;
	logic         rd;
	logic         wr;
	logic         fetch_mk;
	logic         rf_on;
	logic         drv;
	logic         t1b;
	logic         mid;
	logic         t3a;
	logic         t3b4a;

	// apb slave, zero wait except a command write while one is pending
	assign acc = psel && penable;
	assign pready = !(psel && pwrite && paddr == REG_CMD && cmd_pend_r);
	assign wr_en = acc && pwrite && pready && hit;
	assign pslverr = acc && !hit;

	assign stat[ST_BUSY] = cyc.busy;
	assign stat[ST_PEND] = cmd_pend_r;
	assign stat[ST_HALTED] = halted_r;
	assign stat[ST_HOLDACK] = ack_r;
	assign stat[ST_IRQ_EN] = irq_enable_latch_r;
	assign stat[ST_IM_LSB +: 2] = im_r;
	assign stat[ST_NMIPEND] = nmi_pend_r;
	assign stat[ST_FLOAT] = float_r;

	always_comb begin
		hit = 1'b1;
		prdata = '0;
		unique case (paddr)
			REG_CMD:    prdata[2:0] = cmd_code_r;
			REG_ADDR:   prdata[15:0] = cmd_addr_r;
			REG_WDATA:  prdata[7:0] = wdata_r;
			REG_RDATA:  prdata[7:0] = rdata_r;
			REG_STATUS: prdata[ST_W-1:0] = stat;
			REG_CFG:    prdata[CFG_IM_LSB+1:0] = {im_r, irq_enable_latch_r};
			REG_PROG:   prdata[15:0] = program_counter_r;
			REG_VPAGE:  prdata[7:0] = vector_page_r;
			REG_RFCNT:  prdata[7:0] = refresh_counter_r;
			default:    hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_code_r <= CMD_FETCH;
			cmd_addr_r <= PROG_RESET;
			wdata_r <= BYTE_RESET;
			vector_page_r <= BYTE_RESET;
		end else if (wr_en) begin
			if (paddr == REG_CMD)
				cmd_code_r <= pwdata[2:0];
			if (paddr == REG_ADDR)
				cmd_addr_r <= pwdata[15:0];
			if (paddr == REG_WDATA)
				wdata_r <= pwdata[7:0];
			if (paddr == REG_VPAGE)
				vector_page_r <= pwdata[7:0];
		end
	end

	// machine cycle choice at the end of each cycle or while idle
	assign slot = !float_r && (!cyc.busy || cyc.last);
	assign done = cyc.last;
	assign nmi_fall = nmi_q_r && !nmi_n;

	always_comb begin
		start_nxt = 1'b0;
		kind_nxt = K_FETCH;
		op_nxt = OP_CMD;
		if (slot && bus_hold_request_n) begin
			if (boundary_r && nmi_pend_r) begin
				start_nxt = 1'b1;
				op_nxt = OP_NMI;
			end else if (boundary_r && !irq_request_n && irq_enable_latch_r) begin
				start_nxt = 1'b1;
				kind_nxt = K_INTACK;
				op_nxt = OP_INT;
			end else if (halted_r) begin
				start_nxt = 1'b1;
				op_nxt = OP_NOP;
			end else if (cmd_pend_r) begin
				start_nxt = 1'b1;
				unique case (cmd_code_r)
					CMD_MEMRD: kind_nxt = K_MEMRD;
					CMD_MEMWR: kind_nxt = K_MEMWR;
					CMD_IORD:  kind_nxt = K_IORD;
					CMD_IOWR:  kind_nxt = K_IOWR;
					default:   kind_nxt = K_FETCH;
				endcase
			end
		end
	end

	assign cyc.start = start_nxt;
	assign cyc.kind = kind_nxt;
	assign cyc.wait_n = wait_request_n;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= OP_NOP;
			cur_code_r <= CMD_FETCH;
		end else if (start_nxt) begin
			op_r <= op_nxt;
			cur_code_r <= cmd_code_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_pend_r <= 1'b0;
		else if (wr_en && paddr == REG_CMD)
			cmd_pend_r <= 1'b1;
		else if (start_nxt && op_nxt == OP_CMD)
			cmd_pend_r <= 1'b0;
	end

	// an edge in the cycle that accepts the old one stays pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_q_r <= 1'b1;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_q_r <= nmi_n;
			if (nmi_fall)
				nmi_pend_r <= 1'b1;
			else if (start_nxt && op_nxt == OP_NMI)
				nmi_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			boundary_r <= 1'b1;
		else if (done)
			boundary_r <= cyc.kind_now == K_FETCH;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_latch_r <= 1'b0;
			im_r <= IM_RESET;
		end else begin
			if (wr_en && paddr == REG_CFG) begin
				irq_enable_latch_r <= pwdata[CFG_IRQ_EN];
				im_r <= pwdata[CFG_IM_LSB +: 2];
			end
			if (start_nxt && (op_nxt == OP_NMI || op_nxt == OP_INT))
				irq_enable_latch_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter_r <= PROG_RESET;
		end else if (done && op_r == OP_NMI) begin
			program_counter_r <= NMI_VEC;
		end else if (done && op_r == OP_INT) begin
			program_counter_r <= (im_r == IM_VECTORED) ? {vector_page_r, rdata_r} : RST_VEC;
		end else if (done && op_r == OP_CMD && cyc.kind_now == K_FETCH) begin
			program_counter_r <= program_counter_r + 16'h0001;
		end else if (wr_en && paddr == REG_PROG) begin
			program_counter_r <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			halted_r <= 1'b0;
		else if (done && (op_r == OP_NMI || op_r == OP_INT))
			halted_r <= 1'b0;
		else if (done && op_r == OP_CMD && cur_code_r == CMD_HALT)
			halted_r <= 1'b1;
	end

	// refresh row advances after each fetch or acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			refresh_counter_r <= BYTE_RESET;
		else if (done && (cyc.kind_now == K_FETCH || cyc.kind_now == K_INTACK))
			refresh_counter_r[6:0] <= refresh_counter_r[6:0] + RF_STEP;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_r <= BYTE_RESET;
		else if (cyc.xfer && cyc.kind_now != K_MEMWR && cyc.kind_now != K_IOWR)
			rdata_r <= data_i;
	end

	// bus hold: float first, acknowledge a clock later, release in reverse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			float_r <= 1'b1;
			ack_r <= 1'b0;
		end else if (!float_r) begin
			if (slot && !bus_hold_request_n)
				float_r <= 1'b1;
		end else if (!bus_hold_request_n) begin
			ack_r <= 1'b1;
		end else if (ack_r) begin
			ack_r <= 1'b0;
		end else begin
			float_r <= 1'b0;
		end
	end

	// strobe decode from the T state and its half
	assign t1b = cyc.tst == TS_T1 && cyc.ph;
	assign mid = cyc.tst == TS_T2 || cyc.tst == TS_TW;
	assign t3a = cyc.tst == TS_T3 && !cyc.ph;
	assign t3b4a = (cyc.tst == TS_T3 && cyc.ph) || (cyc.tst == TS_T4 && !cyc.ph);

	always_comb begin
		mem_rq = 1'b0;
		io_rq = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		fetch_mk = 1'b0;
		rf_on = 1'b0;
		drv = 1'b0;
		unique case (cyc.kind_now)
			K_FETCH: begin
				fetch_mk = cyc.tst == TS_T1 || mid;
				mem_rq = t1b || mid || t3b4a;
				rd = t1b || mid;
				rf_on = cyc.tst == TS_T3 || cyc.tst == TS_T4;
			end
			K_INTACK: begin
				fetch_mk = cyc.tst == TS_T1 || mid;
				io_rq = cyc.tst == TS_TW;
				mem_rq = t3b4a;
				rf_on = cyc.tst == TS_T3 || cyc.tst == TS_T4;
			end
			K_MEMRD: begin
				mem_rq = t1b || mid || t3a;
				rd = t1b || mid || t3a;
			end
			K_MEMWR: begin
				mem_rq = t1b || mid || t3a;
				wr = (cyc.tst == TS_T2 && cyc.ph) || cyc.tst == TS_TW || t3a;
				drv = t1b || mid || cyc.tst == TS_T3;
			end
			K_IORD: begin
				io_rq = mid || t3a;
				rd = mid || t3a;
			end
			K_IOWR: begin
				io_rq = mid || t3a;
				wr = mid || t3a;
				drv = t1b || mid || cyc.tst == TS_T3;
			end
		endcase
		if (cyc.tst == TS_IDLE) begin
			mem_rq = 1'b0;
			io_rq = 1'b0;
			rd = 1'b0;
			wr = 1'b0;
			fetch_mk = 1'b0;
			rf_on = 1'b0;
			drv = 1'b0;
		end
	end

	always_comb begin
		if (rf_on)
			addr_o = {vector_page_r, refresh_counter_r};
		else if (cyc.kind_now == K_FETCH || cyc.kind_now == K_INTACK || !cyc.busy)
			addr_o = program_counter_r;
		else
			addr_o = cmd_addr_r;
	end

	assign addr_oe = !float_r;
	assign ctl_oe = !float_r;
	assign data_o = wdata_r;
	assign data_oe = !float_r && drv;
	assign memory_request_n = float_r || !mem_rq;
	assign io_request_n = float_r || !io_rq;
	assign read_strobe_n = float_r || !rd;
	assign write_strobe_n = float_r || !wr;
	assign opcode_fetch_marker_n = !fetch_mk;
	assign refresh_strobe_n = !rf_on;
	assign halted_indicator_n = !halted_r;
	assign bus_hold_ack_n = !ack_r;
endmodule

// ==== dv/cbc_top_asserts.sv ====
module cbc_top_asserts (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       addr_oe,
	input wire logic [7:0] data_o,
	input wire logic       data_oe,
	input wire logic       ctl_oe,
	input wire logic       memory_request_n,
	input wire logic       io_request_n,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic       opcode_fetch_marker_n,
	input wire logic       refresh_strobe_n,
	input wire logic       halted_indicator_n,
	input wire logic       bus_hold_ack_n,
	input wire logic       wait_request_n,
	input wire logic       bus_hold_request_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] hold_cnt_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// cycles of steady hold request with no external wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_cnt_r <= 5'h00;
		else if (bus_hold_request_n || !wait_request_n)
			hold_cnt_r <= 5'h00;
		else if (hold_cnt_r != 5'h1f)
			hold_cnt_r <= hold_cnt_r + 5'h01;
	end

	a_hold_granted: assert property (hold_cnt_r == 5'h18 |-> !bus_hold_ack_n)
		else $error("hold request not granted in time");
	a_ack_floated: assert property (!bus_hold_ack_n |-> !addr_oe && !data_oe && !ctl_oe)
		else $error("hold ack while bus driven");
	a_reset_floats: assert property ($rose(presetn) |-> !addr_oe && !data_oe && !ctl_oe
		&& bus_hold_ack_n && halted_indicator_n && refresh_strobe_n)
		else $error("outputs active during reset");
	a_one_kind: assert property (memory_request_n || io_request_n)
		else $error("memory and io request together");
	a_io_strobe: assert property (!io_request_n && opcode_fetch_marker_n
		|-> read_strobe_n != write_strobe_n)
		else $error("io request without one strobe");
	a_fetch_order: assert property ($fell(opcode_fetch_marker_n)
		|-> addr_oe && memory_request_n ##1 memory_request_n == read_strobe_n)
		else $error("fetch request order wrong");
	a_write_data: assert property (!write_strobe_n |-> data_oe && $stable(data_o))
		else $error("write strobe without stable data");
	a_refresh_alone: assert property (!refresh_strobe_n |-> read_strobe_n
		&& write_strobe_n && opcode_fetch_marker_n && io_request_n)
		else $error("refresh overlaps a transfer");
	a_wait_holds: assert property (!wait_request_n && !$past(wait_request_n)
		&& !$past(wait_request_n, 2) && !read_strobe_n |=> !read_strobe_n)
		else $error("read ended during wait");
	a_io_auto_wait: assert property ($fell(io_request_n) && opcode_fetch_marker_n
		|-> ((!io_request_n)[*5] ##1 io_request_n) or (##[0:4] !wait_request_n))
		else $error("io cycle length wrong");
	a_ack_two_waits: assert property ($fell(io_request_n) && !opcode_fetch_marker_n
		|-> ((!io_request_n && !opcode_fetch_marker_n)[*4] ##1 io_request_n)
		or (##[0:3] !wait_request_n))
		else $error("interrupt acknowledge length wrong");
	a_halt_no_write: assert property (!halted_indicator_n |-> write_strobe_n && !data_oe)
		else $error("write while halted");

	c_fetch: cover property ($fell(opcode_fetch_marker_n) ##1 !memory_request_n);
	c_io: cover property ($fell(io_request_n) && opcode_fetch_marker_n);
	c_intack: cover property ($fell(io_request_n) && !opcode_fetch_marker_n);
	c_hold: cover property ($fell(bus_hold_ack_n));
endmodule

bind cbc_top cbc_top_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .addr_oe(addr_oe), .data_o(data_o),
	.data_oe(data_oe), .ctl_oe(ctl_oe), .memory_request_n(memory_request_n),
	.io_request_n(io_request_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .opcode_fetch_marker_n(opcode_fetch_marker_n),
	.refresh_strobe_n(refresh_strobe_n), .halted_indicator_n(halted_indicator_n),
	.bus_hold_ack_n(bus_hold_ack_n), .wait_request_n(wait_request_n),
	.bus_hold_request_n(bus_hold_request_n)
);

// ==== dv/cbc_mem_model.sv ====
module cbc_mem_model (
	input wire logic        pclk,
	input wire logic [15:0] addr,
	input wire logic        ctl_oe,
	input wire logic        memory_request_n,
	input wire logic        io_request_n,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        opcode_fetch_marker_n,
	input wire logic [7:0]  wdata,
	output logic     [7:0]  rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	parameter logic [7:0] VECTOR = 8'h5a;
	logic [7:0] mem [256];
	logic [7:0] last = 8'h00;
	logic       ack;
	logic       drv;

	assign ack = !io_request_n && !opcode_fetch_marker_n;
	// drive only under read strobe or vector fetch
	assign drv = ctl_oe && (!read_strobe_n || ack);
	// released bus shows the inverse of the last byte
	always_comb
		rdata = !drv ? ~last : ack ? VECTOR : !io_request_n ? ~addr[7:0] : mem[addr[7:0]];

	always @(posedge pclk) begin
		if (drv)
			last <= rdata;
		if (ctl_oe && !write_strobe_n && !memory_request_n)
			mem[addr[7:0]] <= wdata;
	end

	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end
endmodule

// ==== dv/cbc_top_bench.sv ====
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
		end \
	end

module cbc_top_bench import cbc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, addr_oe, data_oe, ctl_oe;
	logic [15:0] addr_o;
	logic [7:0]  data_i, data_o, mdat;
	logic        mem_rq_n, io_rq_n, rd_n, wr_n, fetch_mk_n, rf_n, halt_n, ack_n;
	logic        wait_n = 1'b1, hold_n = 1'b1, irq_n = 1'b1, nmi_n = 1'b1;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	assign data_i = data_oe ? data_o : mdat;

	cbc_top dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.addr_o(addr_o), .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o),
		.data_oe(data_oe), .ctl_oe(ctl_oe), .memory_request_n(mem_rq_n), .io_request_n(io_rq_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .opcode_fetch_marker_n(fetch_mk_n),
		.refresh_strobe_n(rf_n), .halted_indicator_n(halt_n), .bus_hold_ack_n(ack_n),
		.wait_request_n(wait_n), .bus_hold_request_n(hold_n), .irq_request_n(irq_n),
		.nmi_n(nmi_n)
	);

	cbc_mem_model u_mem (
		.pclk(pclk), .addr(addr_o), .ctl_oe(ctl_oe), .memory_request_n(mem_rq_n),
		.io_request_n(io_rq_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.opcode_fetch_marker_n(fetch_mk_n), .wdata(data_o), .rdata(mdat)
	);

	initial begin
		forever #5 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic hang();
		n_mismatch++;
		print_verdict();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100)
			hang();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic cmd(input logic [2:0] c);
		wr(REG_CMD, {29'h0, c});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while ((rd[ST_BUSY] | rd[ST_PEND] | rd[ST_NMIPEND]) !== 1'b0 && n < 200);
		if (n >= 200)
			hang();
	endtask

	// waits on the halt indicator when use_halt is set, else on hold ack
	task automatic wait_for(input logic use_halt, input logic v);
		int n;
		for (n = 0; n < 200 && (use_halt ? halt_n : ack_n) !== v; n++)
			@(posedge pclk);
		if (n >= 200)
			hang();
	endtask

	task automatic test_end(input string s);
		$display("test %s finished", s);
	endtask

	task automatic reset_checks();
		rdchk(REG_PROG, 32'h0);
		rdchk(REG_CFG, 32'h0);
		rdchk(REG_VPAGE, 32'h0);
		rdchk(REG_RFCNT, 32'h0);
		rdchk(8'h40, 32'h0);
		`CHK(err, 1'b1)
		`CHK(addr_oe, 1'b1)
		test_end("reset");
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		reset_checks();
		wr(REG_ADDR, 32'h0000_0012);
		wr(REG_WDATA, 32'h0000_003c);
		cmd(CMD_MEMWR);
		wait_idle();
		cmd(CMD_MEMRD);
		wait_idle();
		rdchk(REG_RDATA, 32'h0000_003c);
		test_end("memory");
		wr(REG_PROG, 32'h0000_0020);
		cmd(CMD_FETCH);
		wait_idle();
		rdchk(REG_RDATA, 32'h0000_0085);
		rdchk(REG_PROG, 32'h0000_0021);
		rdchk(REG_RFCNT, 32'h0000_0001);
		test_end("fetch");
		wr(REG_ADDR, 32'h0000_1244);
		cmd(CMD_IORD);
		wait_idle();
		rdchk(REG_RDATA, 32'h0000_00bb);
		cmd(CMD_IOWR);
		wait_idle();
		test_end("io");
		wait_n <= 1'b0;
		cmd(CMD_MEMRD);
		repeat (20) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[ST_BUSY], 1'b1)
		wait_n <= 1'b1;
		wait_idle();
		rdchk(REG_RDATA, 32'h0000_00e1);
		test_end("wait");
		cmd(CMD_FETCH);
		hold_n <= 1'b0;
		wait_for(1'b0, 1'b0);
		`CHK({addr_oe, data_oe, ctl_oe}, 3'b000)
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[ST_HOLDACK], 1'b1)
		// long hold so the grant-time check sees a steady request
		repeat (24) @(posedge pclk);
		hold_n <= 1'b1;
		wait_for(1'b0, 1'b1);
		wait_idle();
		rdchk(REG_PROG, 32'h0000_0022);
		test_end("hold");
		nmi_n <= 1'b0;
		repeat (2) @(posedge pclk);
		nmi_n <= 1'b1;
		wait_idle();
		rdchk(REG_PROG, 32'h0000_0066);
		test_end("nmi");
		irq_n <= 1'b0;
		cmd(CMD_FETCH);
		wait_idle();
		rdchk(REG_PROG, 32'h0000_0067);
		wr(REG_VPAGE, 32'h0000_0012);
		cmd(CMD_HALT);
		wait_for(1'b1, 1'b0);
		wr(REG_CFG, 32'h0000_0005);
		wait_for(1'b1, 1'b1);
		irq_n <= 1'b1;
		wait_idle();
		rdchk(REG_PROG, 32'h0000_125a);
		rdchk(REG_CFG, 32'h0000_0004);
		test_end("interrupt");
		cmd(CMD_FETCH);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		reset_checks();
		print_verdict();
	end
endmodule
